// [dcdiv_top.sv]
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps

module dcdiv_top #(
    parameter int STAB_COUNT = dcdiv_pkg::STAB_CYCLES
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control pins
    input wire logic reference_control_pin,
    input wire logic main_control_pin,
    // clock outputs with enables
    output logic reference_clock_out,
    output logic reference_clock_oe,
    output logic main_clock_out,
    output logic main_clock_oe,
    output logic device_powered_down
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [dcdiv_pkg::PERIOD_W-1:0] prescale_period(
        input logic [1:0] ps);
        prescale_period = dcdiv_pkg::MCLK_PERIOD << ps;
    endfunction : prescale_period

    function automatic logic [dcdiv_pkg::PERIOD_W-1:0] next_count(
        input logic [dcdiv_pkg::PERIOD_W-1:0] cnt,
        input logic [dcdiv_pkg::PERIOD_W-1:0] prd);
        if (cnt >= prd - 16'h0001) begin
            next_count = '0;
        end else begin
            next_count = cnt + 16'h0001;
        end
    endfunction : next_count

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dcdiv_pkg::dcdiv_cfg_t cfg_ff;
    dcdiv_pkg::dcdiv_cfg_t stored_ff;
    dcdiv_pkg::dcdiv_state_t state_ff;
    dcdiv_pkg::dcdiv_state_t nxt_state;
    logic [13:0] stab_cnt_ff;
    logic ref_pin_meta_ff, ref_pin_ff;
    logic main_pin_meta_ff, main_pin_ff;
    logic [dcdiv_pkg::PERIOD_W-1:0] ref_cnt_ff, ref_prd_ff;
    logic [dcdiv_pkg::PERIOD_W-1:0] main_cnt_ff, main_prd_ff;
    logic [dcdiv_pkg::PERIOD_W-1:0] nxt_ref_cnt, nxt_ref_prd;
    logic [dcdiv_pkg::PERIOD_W-1:0] nxt_main_cnt, nxt_main_prd;
    logic [dcdiv_pkg::PERIOD_W-1:0] ref_target, main_target;
    logic ref_out_ff, main_out_ff, ref_oe_ff, main_oe_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic ref_gate, ref_use_prescale, ref_pd_req, main_gate, main_pd_req;
    logic pd_req, running, setup, wr_ok;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_pin_meta_ff <= 1'b0;
            ref_pin_ff <= 1'b0;
            main_pin_meta_ff <= 1'b0;
            main_pin_ff <= 1'b0;
        end else if (clk_en) begin
            ref_pin_meta_ff <= reference_control_pin;
            ref_pin_ff <= ref_pin_meta_ff;
            main_pin_meta_ff <= main_control_pin;
            main_pin_ff <= main_pin_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // control pin role decode
    // ----------------------------------------------------------------
    always_comb begin
        ref_gate = 1'b0;
        ref_use_prescale = cfg_ff.ref_sel;
        ref_pd_req = 1'b0;
        if (cfg_ff.ref_pdn) begin
            ref_pd_req = ref_pin_ff;
            ref_gate = !ref_pin_ff;
        end else if (cfg_ff.ref_en) begin
            ref_gate = !ref_pin_ff;
        end else if (cfg_ff.ref_sel) begin
            ref_gate = 1'b1;
            ref_use_prescale = ref_pin_ff;
        end else begin
            ref_pd_req = ref_pin_ff;
        end
        main_gate = !main_pin_ff;
        main_pd_req = cfg_ff.main_pdn & main_pin_ff;
    end

    assign pd_req = ref_pd_req | main_pd_req;
    assign running = (state_ff == dcdiv_pkg::DCDIV_RUN);

    // ----------------------------------------------------------------
    // power sequencing
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            dcdiv_pkg::DCDIV_LOAD: nxt_state = dcdiv_pkg::DCDIV_STAB;
            dcdiv_pkg::DCDIV_STAB: begin
                if (pd_req) begin
                    nxt_state = dcdiv_pkg::DCDIV_DOWN;
                end else if (stab_cnt_ff == 14'(STAB_COUNT - 1)) begin
                    nxt_state = dcdiv_pkg::DCDIV_RUN;
                end
            end
            dcdiv_pkg::DCDIV_RUN: begin
                if (pd_req) begin
                    nxt_state = dcdiv_pkg::DCDIV_DRAIN;
                end
            end
            dcdiv_pkg::DCDIV_DRAIN: begin
                // both outputs must be floated before the core stops
                if (!ref_oe_ff && !main_oe_ff) begin
                    nxt_state = dcdiv_pkg::DCDIV_DOWN;
                end
            end
            dcdiv_pkg::DCDIV_DOWN: begin
                if (!pd_req) begin
                    nxt_state = dcdiv_pkg::DCDIV_STAB;
                end
            end
            default: nxt_state = dcdiv_pkg::DCDIV_LOAD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= dcdiv_pkg::DCDIV_LOAD;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_cnt_ff <= '0;
        end else if (clk_en) begin
            if (state_ff == dcdiv_pkg::DCDIV_STAB) begin
                stab_cnt_ff <= stab_cnt_ff + 14'h0001;
            end else begin
                stab_cnt_ff <= '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign setup = psel && !penable;
    // writes are refused while the core is powered down
    assign wr_ok = (state_ff != dcdiv_pkg::DCDIV_DOWN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else if (clk_en && setup) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
            unique case (paddr)
                dcdiv_pkg::MODE_ADDR: begin
                    prdata_ff <= {17'h00000, cfg_ff.main_pdn, cfg_ff.ref_pdn,
                        cfg_ff.ref_sel, cfg_ff.ref_en, cfg_ff.ref_ps,
                        cfg_ff.main_ps, cfg_ff.div_bypass, 6'h00};
                    pslverr_ff <= pwrite && !wr_ok;
                end
                dcdiv_pkg::DIVISOR_ADDR: begin
                    prdata_ff <= {16'h0000, cfg_ff.div_n, 6'h00};
                    pslverr_ff <= pwrite && !wr_ok;
                end
                dcdiv_pkg::STORE_ADDR: pslverr_ff <= pwrite && !wr_ok;
                dcdiv_pkg::STATUS_ADDR: begin
                    prdata_ff[dcdiv_pkg::ST_DOWN_POS] <=
                        (state_ff == dcdiv_pkg::DCDIV_DOWN);
                    prdata_ff[dcdiv_pkg::ST_STABLE_POS] <= running;
                    prdata_ff[dcdiv_pkg::ST_REF_OE_POS] <= ref_oe_ff;
                    prdata_ff[dcdiv_pkg::ST_MAIN_OE_POS] <= main_oe_ff;
                    pslverr_ff <= pwrite;
                end
                default: pslverr_ff <= 1'b1;
            endcase
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign pslverr = psel && penable && pslverr_ff;

    // ----------------------------------------------------------------
    // working and stored configuration
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= dcdiv_pkg::CFG_RESET;
        end else if (clk_en) begin
            if (state_ff == dcdiv_pkg::DCDIV_LOAD) begin
                cfg_ff <= stored_ff;
            end else if (psel && penable && pwrite && wr_ok) begin
                if (paddr == dcdiv_pkg::MODE_ADDR) begin
                    cfg_ff.main_pdn <= pwdata[dcdiv_pkg::MAIN_PDN_POS];
                    cfg_ff.ref_pdn <= pwdata[dcdiv_pkg::REF_PDN_POS];
                    cfg_ff.ref_sel <= pwdata[dcdiv_pkg::REF_SEL_POS];
                    cfg_ff.ref_en <= pwdata[dcdiv_pkg::REF_EN_POS];
                    cfg_ff.ref_ps <= pwdata[dcdiv_pkg::REF_PS_HI_POS:
                        dcdiv_pkg::REF_PS_LO_POS];
                    cfg_ff.main_ps <= pwdata[dcdiv_pkg::MAIN_PS_HI_POS:
                        dcdiv_pkg::MAIN_PS_LO_POS];
                    cfg_ff.div_bypass <= pwdata[dcdiv_pkg::BYPASS_POS];
                end else if (paddr == dcdiv_pkg::DIVISOR_ADDR) begin
                    cfg_ff.div_n <= pwdata[dcdiv_pkg::DIVN_LSB_POS +: dcdiv_pkg::DIVN_W];
                end
            end
        end
    end

    // stands in for nonvolatile cells: survives power-down, not presetn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stored_ff <= dcdiv_pkg::CFG_RESET;
        end else if (clk_en && psel && penable && pwrite && wr_ok
                     && paddr == dcdiv_pkg::STORE_ADDR) begin
            stored_ff <= cfg_ff;
        end
    end

    // ----------------------------------------------------------------
    // dividers: master clock is pclk/2, each output a counter
    // ----------------------------------------------------------------
    always_comb begin
        ref_target = ref_use_prescale ? prescale_period(cfg_ff.ref_ps)
                                      : dcdiv_pkg::MCLK_PERIOD;
        main_target = cfg_ff.div_bypass ? prescale_period(cfg_ff.main_ps)
            : 16'(({6'h00, cfg_ff.div_n} + dcdiv_pkg::DIVN_OFFSET)
                  << (3'(cfg_ff.main_ps) + 3'h1));
        nxt_ref_cnt = next_count(ref_cnt_ff, ref_prd_ff);
        nxt_main_cnt = next_count(main_cnt_ff, main_prd_ff);
        // new ratios are taken only when a period wraps
        nxt_ref_prd = (nxt_ref_cnt == '0) ? ref_target : ref_prd_ff;
        nxt_main_prd = (nxt_main_cnt == '0) ? main_target : main_prd_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_cnt_ff <= '0;
            ref_prd_ff <= dcdiv_pkg::MCLK_PERIOD;
            ref_out_ff <= 1'b0;
        end else if (clk_en) begin
            // cleared on the way into power-down so no high level is left standing
            if (nxt_state == dcdiv_pkg::DCDIV_DOWN) begin
                ref_cnt_ff <= '0;
                ref_out_ff <= 1'b0;
            end else begin
                ref_cnt_ff <= nxt_ref_cnt;
                ref_prd_ff <= nxt_ref_prd;
                ref_out_ff <= nxt_ref_cnt < (nxt_ref_prd >> 1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_cnt_ff <= '0;
            main_prd_ff <= dcdiv_pkg::MCLK_PERIOD;
            main_out_ff <= 1'b0;
        end else if (clk_en) begin
            if (nxt_state == dcdiv_pkg::DCDIV_DOWN) begin
                main_cnt_ff <= '0;
                main_out_ff <= 1'b0;
            end else begin
                main_cnt_ff <= nxt_main_cnt;
                main_prd_ff <= nxt_main_prd;
                main_out_ff <= nxt_main_cnt < (nxt_main_prd >> 1);
            end
        end
    end

    // ----------------------------------------------------------------
    // smart output enables
    // ----------------------------------------------------------------
    // enables move only while the driven level is low, so no runt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_oe_ff <= 1'b0;
            main_oe_ff <= 1'b0;
        end else if (clk_en) begin
            if (!ref_out_ff) begin
                ref_oe_ff <= running && ref_gate && !pd_req;
            end
            if (!main_out_ff) begin
                main_oe_ff <= running && main_gate && !pd_req;
            end
        end
    end

    assign reference_clock_out = ref_out_ff;
    assign reference_clock_oe = ref_oe_ff;
    assign main_clock_out = main_out_ff;
    assign main_clock_oe = main_oe_ff;
    assign device_powered_down = (state_ff == dcdiv_pkg::DCDIV_DOWN);

endmodule : dcdiv_top

// [dcdiv_pkg.sv]
package dcdiv_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] MODE_ADDR = 12'h000;
    localparam logic [11:0] DIVISOR_ADDR = 12'h004;
    localparam logic [11:0] STORE_ADDR = 12'h008;
    localparam logic [11:0] STATUS_ADDR = 12'h00C;

    // ----------------------------------------------------------------
    // mode and divisor word field positions
    // ----------------------------------------------------------------
    localparam int MAIN_PDN_POS = 14;
    localparam int REF_PDN_POS = 13;
    localparam int REF_SEL_POS = 12;
    localparam int REF_EN_POS = 11;
    localparam int REF_PS_HI_POS = 10;
    localparam int REF_PS_LO_POS = 9;
    localparam int MAIN_PS_HI_POS = 8;
    localparam int MAIN_PS_LO_POS = 7;
    localparam int BYPASS_POS = 6;
    localparam int DIVN_LSB_POS = 6;
    localparam int DIVN_W = 10;

    // ----------------------------------------------------------------
    // status word field positions
    // ----------------------------------------------------------------
    localparam int ST_DOWN_POS = 0;
    localparam int ST_STABLE_POS = 1;
    localparam int ST_REF_OE_POS = 2;
    localparam int ST_MAIN_OE_POS = 3;

    // ----------------------------------------------------------------
    // timing and arithmetic
    // ----------------------------------------------------------------
    localparam int STAB_CYCLES = 8000;
    localparam int PERIOD_W = 16;
    localparam logic [PERIOD_W-1:0] MCLK_PERIOD = 16'h0002;
    localparam logic [PERIOD_W-1:0] DIVN_OFFSET = 16'h0002;

    typedef struct packed {
        logic main_pdn;
        logic ref_pdn;
        logic ref_sel;
        logic ref_en;
        logic [1:0] ref_ps;
        logic [1:0] main_ps;
        logic div_bypass;
        logic [DIVN_W-1:0] div_n;
    } dcdiv_cfg_t;

    // enable and select bits set, prescalers by 1, divisor 2
    localparam dcdiv_cfg_t CFG_RESET = '{
        main_pdn: 1'b0, ref_pdn: 1'b0, ref_sel: 1'b1, ref_en: 1'b1,
        ref_ps: 2'h0, main_ps: 2'h0, div_bypass: 1'b0, div_n: 10'h000};

    typedef enum logic [2:0] {
        DCDIV_LOAD = 3'b000,
        DCDIV_STAB = 3'b001,
        DCDIV_RUN = 3'b010,
        DCDIV_DRAIN = 3'b011,
        DCDIV_DOWN = 3'b100
    } dcdiv_state_t;

endpackage : dcdiv_pkg

// [dcdiv_top_chk.sv]
`timescale 1ns/100ps
module dcdiv_top_chk #(
    parameter int STAB_COUNT = dcdiv_pkg::STAB_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic reference_control_pin,
    input wire logic main_control_pin,
    input wire logic reference_clock_out,
    input wire logic reference_clock_oe,
    input wire logic main_clock_out,
    input wire logic main_clock_oe,
    input wire logic device_powered_down
);
    logic [15:0] up_ff;
    // saturates past the settle time so it never wraps back into the hold window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_ff <= 16'h0000;
        end else if (up_ff < 16'(STAB_COUNT)) begin
            up_ff <= up_ff + 16'h0001;
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_down_wr;
        psel && !penable && pwrite && device_powered_down && paddr < dcdiv_pkg::STATUS_ADDR;
    endsequence
    sequence s_unmapped;
        psel && !penable && paddr > dcdiv_pkg::STATUS_ADDR;
    endsequence
    AST_PREADY: assert property (pready)
        else $error("pready low");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
        else $error("error flag outside access phase");
    AST_DOWN_REFUSE: assert property (s_down_wr ##1 s_acc |-> pslverr)
        else $error("write accepted while powered down");
    AST_UNMAPPED: assert property (s_unmapped ##1 s_acc |-> pslverr)
        else $error("unmapped access not refused");
    AST_STAB_HOLD: assert property (
        up_ff < 16'(STAB_COUNT) |-> !reference_clock_oe && !main_clock_oe)
        else $error("output enabled before settle time");
    AST_DOWN_DARK: assert property (
        device_powered_down |-> !reference_clock_oe && !main_clock_oe)
        else $error("output driven while powered down");
    AST_DOWN_LOW: assert property (
        device_powered_down |-> !reference_clock_out && !main_clock_out)
        else $error("clock running while powered down");
    AST_REF_FALL_LOW: assert property (
        $fell(reference_clock_oe) |-> !$past(reference_clock_out))
        else $error("reference output floated while high");
    AST_MAIN_FALL_LOW: assert property ($fell(main_clock_oe) |-> !$past(main_clock_out))
        else $error("main output floated while high");
endmodule : dcdiv_top_chk

bind dcdiv_top dcdiv_top_chk #(.STAB_COUNT(STAB_COUNT)) chk_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reference_control_pin(reference_control_pin),
    .main_control_pin(main_control_pin), .reference_clock_out(reference_clock_out),
    .reference_clock_oe(reference_clock_oe), .main_clock_out(main_clock_out),
    .main_clock_oe(main_clock_oe), .device_powered_down(device_powered_down));

// [dcdiv_clk_mon.sv]
`timescale 1ns/100ps
// downstream logic that measures a generated clock in pclk cycles
module dcdiv_clk_mon (
    // sampling clock and observed clock
    input wire logic pclk,
    input wire logic clk_out,
    // last completed rise-to-rise period and high phase
    output logic [15:0] period_ff,
    output logic [15:0] high_ff
);
    logic prev_ff = 1'b0;
    logic [15:0] cnt_ff = 16'h0000;
    logic [15:0] run_ff = 16'h0000;
    always_ff @(posedge pclk) begin
        prev_ff <= clk_out;
        if (clk_out && !prev_ff) begin
            period_ff <= cnt_ff;
            cnt_ff <= 16'h0001;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
    always_ff @(posedge pclk) begin
        run_ff <= clk_out ? run_ff + 16'h0001 : 16'h0000;
        if (!clk_out && prev_ff) begin
            high_ff <= run_ff;
        end
    end
endmodule : dcdiv_clk_mon

// [tb_dual_output_clock_divider.sv]
`timescale 1ns/100ps
module tb_dual_output_clock_divider;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic reference_control_pin = 1'b0;
    logic main_control_pin = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, ref_out, ref_oe, main_out, main_oe, down;
    logic [15:0] rper, rhi, mper, mhi;
    int errors = 0;
    int n_checks = 0;
    always #50 pclk = ~pclk;
    dcdiv_top #(.STAB_COUNT(16)) dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reference_control_pin(reference_control_pin),
        .main_control_pin(main_control_pin), .reference_clock_out(ref_out),
        .reference_clock_oe(ref_oe), .main_clock_out(main_out), .main_clock_oe(main_oe),
        .device_powered_down(down));
    dcdiv_clk_mon ref_mon_u (.pclk(pclk), .clk_out(ref_out), .period_ff(rper), .high_ff(rhi));
    dcdiv_clk_mon main_mon_u (.pclk(pclk), .clk_out(main_out), .period_ff(mper), .high_ff(mhi));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i >= 50) begin
            errors++;
            finish_test;
        end
    endtask : apb
    // bounded wait on 0: powered down, 1: reference enable, 2: main enable
    task wsig(input int k, input logic v);
        for (int i = 0; i < 4000; i++) begin
            if ((k == 0 ? down : k == 1 ? ref_oe : main_oe) === v) return;
            @(posedge pclk);
        end
        errors++;
        finish_test;
    endtask : wsig
    task do_reset;
        presetn <= 1'b0;
        wt(12);
        presetn <= 1'b1;
        wt(1);
    endtask : do_reset
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_defaults;
        apb(1'b0, dcdiv_pkg::MODE_ADDR, 32'h0);
        chk(rd, 32'h1800);
        apb(1'b0, dcdiv_pkg::DIVISOR_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, dcdiv_pkg::STATUS_ADDR, 32'hF);
        chk({31'h0, er}, 32'h1);
        wsig(2, 1'b1);
        wt(6);
        apb(1'b0, dcdiv_pkg::STATUS_ADDR, 32'h0);
        chk(rd & 32'hF, 32'hE);
        $display("test defaults done");
    endtask : t_defaults
    task t_ref;
        for (int ps = 0; ps < 4; ps++) begin
            apb(1'b1, dcdiv_pkg::MODE_ADDR, 32'h1800 | (32'(ps) << 9));
            wt(50);
            chk({16'h0, rper}, 32'(2 << ps));
        end
        apb(1'b1, dcdiv_pkg::MODE_ADDR, 32'h0E00);
        wt(50);
        chk({16'h0, rper}, 32'h2);
        $display("test reference done");
    endtask : t_ref
    task t_main;
        logic [9:0] ns[4] = '{10'h000, 10'h003, 10'h3FF, 10'h001};
        int pss[4] = '{0, 3, 0, 0};
        int p;
        for (int ps = 0; ps < 4; ps++) begin
            apb(1'b1, dcdiv_pkg::MODE_ADDR, 32'h1840 | (32'(ps) << 7));
            wt(60);
            chk({16'h0, mper}, 32'(2 << ps));
        end
        for (int i = 0; i < 4; i++) begin
            p = (int'(ns[i]) + 2) * (2 << pss[i]);
            apb(1'b1, dcdiv_pkg::DIVISOR_ADDR, 32'(ns[i]) << 6);
            apb(1'b1, dcdiv_pkg::MODE_ADDR, 32'h1800 | (32'(pss[i]) << 7));
            wt(3 * p + 2100);
            chk({16'h0, mper}, 32'(p));
            chk({16'h0, mhi}, 32'(p / 2));
        end
        $display("test main done");
    endtask : t_main
    task t_fsel;
        apb(1'b1, dcdiv_pkg::MODE_ADDR, 32'h1400);
        reference_control_pin <= 1'b1;
        wt(50);
        chk({16'h0, rper}, 32'h8);
        reference_control_pin <= 1'b0;
        wt(50);
        chk({16'h0, rper}, 32'h2);
        $display("test select done");
    endtask : t_fsel
    task t_gate;
        apb(1'b1, dcdiv_pkg::MODE_ADDR, 32'h1800);
        reference_control_pin <= 1'b1;
        wsig(1, 1'b0);
        wt(4);
        chk({31'h0, down}, 32'h0);
        main_control_pin <= 1'b1;
        wsig(2, 1'b0);
        wt(4);
        chk({31'h0, down}, 32'h0);
        reference_control_pin <= 1'b0;
        main_control_pin <= 1'b0;
        wsig(1, 1'b1);
        wsig(2, 1'b1);
        $display("test gating done");
    endtask : t_gate
    task t_pdn;
        logic [31:0] md[4] = '{32'h5800, 32'h3800, 32'h0000, 32'h7800};
        logic pn[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, dcdiv_pkg::MODE_ADDR, md[i]);
            wt(5);
            if (pn[i]) main_control_pin <= 1'b1;
            else reference_control_pin <= 1'b1;
            wsig(0, 1'b1);
            chk({30'h0, ref_oe, main_oe}, 32'h0);
            apb(1'b1, dcdiv_pkg::DIVISOR_ADDR, 32'h80);
            chk({31'h0, er}, 32'h1);
            main_control_pin <= 1'b0;
            reference_control_pin <= 1'b0;
            wsig(0, 1'b0);
            wsig(2, 1'b1);
            wt(10);
            chk({31'h0, ref_oe}, {31'h0, |md[i][13:11]});
            apb(1'b0, dcdiv_pkg::DIVISOR_ADDR, 32'h0);
            chk(rd, 32'h40);
        end
        $display("test power down done");
    endtask : t_pdn
    task t_freeze;
        logic [1:0] held;
        clk_en <= 1'b0;
        wt(2);
        held = {ref_out, main_out};
        wt(7);
        chk({30'h0, ref_out, main_out}, {30'h0, held});
        clk_en <= 1'b1;
        wt(2);
        $display("test freeze done");
    endtask : t_freeze
    task t_reload;
        apb(1'b1, dcdiv_pkg::MODE_ADDR, 32'h1E00);
        apb(1'b1, dcdiv_pkg::STORE_ADDR, 32'h1);
        do_reset;
        apb(1'b0, dcdiv_pkg::MODE_ADDR, 32'h0);
        chk(rd, 32'h1800);
        $display("test reload done");
    endtask : t_reload
    initial begin
        do_reset;
        t_defaults;
        t_ref;
        t_main;
        t_fsel;
        t_gate;
        t_pdn;
        t_freeze;
        t_reload;
        finish_test;
    end
endmodule : tb_dual_output_clock_divider
